// ==== shift_field_compare_unit.sv ====
// shift, field, constant and predicate compare execution unit
`timescale 1ns/100ps

// Contract
// [RULE_01] variable shifts by register amount, sign/zero fill
// [RULE_02] extract field to low bits, sign or zero
// [RULE_03] fixed right shift is an extract to top
// [RULE_04] deposit register or constant field, merge or zero
// [RULE_05] fixed left shift is zeroing deposit to top
// [RULE_06] pair shift returns 64 bits of 128
// [RULE_07] same register pair gives rotation
// [RULE_08] 22-bit immediate add; register zero reads zero
// [RULE_09] long move writes full 64-bit immediate
// [RULE_10] false qualifying predicate changes no state
// [RULE_11] one-bit predicates; predicate zero reads one
// [RULE_12] listed ungated operations ignore qualifying predicate
// [RULE_13] compares write two targets, approximations one
// [RULE_14] integer compare, ten relations, two widths
// [RULE_15] narrow compare ignores upper 32 bits
// [RULE_16] bit test uses immediate-selected register bit
// [RULE_17] marker test uses register's deferred exception bit
// [RULE_18] feature test reports implemented feature
// [RULE_19] fp compare under eight relations
// [RULE_20] fp classify sets targets from value class
// [RULE_21] approximation target set only when valid
// [RULE_22] normal compare writes result and complement
// [RULE_23] unconditional compare writes zeros when predicate false
// [RULE_24] shift count 64 up gives zeros/sign
module shift_field_compare_unit #(
   parameter logic [63:0] FEATURE_SET = shift_field_compare_pkg::FEATURES_DEFAULT
) (
   input  wire logic                            clk,    // core clock
   input  wire logic                            rst,    // sync reset
   input  wire shift_field_compare_pkg::issue_s  iss,    // issued op
   input  wire shift_field_compare_pkg::grload_s load,   // other-unit gr write
   output      shift_field_compare_pkg::wb_s     wb_q,   // registered results
   output      logic [63:0]                      pred_q  // predicate file
);

   // ***************************************************
   // register files
   // ***************************************************
   logic [63:0]  gr_mem [0:shift_field_compare_pkg::GR_COUNT-1];
   logic [127:0] nat_q;
   logic [127:0] nat_d;
   logic [63:0]  pred_d;
   shift_field_compare_pkg::wb_s wb_d;

   // operand reads; index zero always reads zero
   logic [63:0] src_a;
   logic [63:0] src_b;
   logic [63:0] opnd_b;
   logic        nat_a;
   logic        nat_b;
   logic        qp;
   assign src_a  = (iss.r2 == 7'h00) ? 64'h0 : gr_mem[iss.r2]; // RULE_08
   assign src_b  = (iss.r3 == 7'h00) ? 64'h0 : gr_mem[iss.r3]; // RULE_08
   assign opnd_b = iss.use_imm ? iss.imm : src_b;
   assign nat_a  = nat_q[iss.r2];
   assign nat_b  = iss.use_imm ? 1'b0 : nat_q[iss.r3];
   assign qp     = pred_q[iss.qp];

   // ***************************************************
   // variable shifts
   // ***************************************************
   // counts of 64 and up saturate instead of wrapping mod 64
   logic        cnt_big;
   logic [63:0] shl_r;
   logic [63:0] shru_r;
   logic [63:0] shr_r;
   logic [63:0] shr_a;
   assign cnt_big = |src_b[63:6];
   assign shl_r   = cnt_big ? 64'h0 : (src_a << src_b[5:0]); // RULE_01 RULE_24
   assign shru_r  = cnt_big ? 64'h0 : (src_a >> src_b[5:0]); // RULE_01 RULE_24
   // own wire: an unsigned branch beside it would make the shift logical
   assign shr_a   = $signed(src_a) >>> src_b[5:0];            // RULE_01
   assign shr_r   = cnt_big ? {64{src_a[63]}} : shr_a;        // RULE_01 RULE_24

   // ***************************************************
   // extract and deposit
   // ***************************************************
   // field mask of len_m1+1 ones; bits past bit 63 simply drop
   logic [63:0] fmask;
   logic [63:0] ext_sh;
   logic        ext_sign;
   logic [63:0] extr_r;
   assign fmask    = {64{1'b1}} >> (6'd63 - iss.len_m1);
   assign ext_sh   = src_a >> iss.pos;
   assign ext_sign = ext_sh[iss.len_m1] & (iss.op == shift_field_compare_pkg::OP_EXTR);
   // a field reaching bit 63 makes this a plain right shift
   assign extr_r   = (ext_sh & fmask) | (~fmask & {64{ext_sign}}); // RULE_02 RULE_03

   logic [63:0] dep_src;
   logic [63:0] dep_mask;
   logic [63:0] dep_base;
   logic [63:0] dep_r;
   assign dep_src  = (iss.dsrc == shift_field_compare_pkg::DS_ZEROS) ? 64'h0 :
                     (iss.dsrc == shift_field_compare_pkg::DS_ONES)  ? {64{1'b1}} :
                     src_a;                                    // RULE_04
   assign dep_mask = fmask << iss.pos;
   assign dep_base = (iss.op == shift_field_compare_pkg::OP_DEPZ) ? 64'h0 : src_b;
   // zeroing deposit reaching bit 63 is a plain left shift
   assign dep_r    = ((dep_src & fmask) << iss.pos) | (dep_base & ~dep_mask); // RULE_04 RULE_05

   // ***************************************************
   // funnel shift and constants
   // ***************************************************
   // same register in both halves rotates
   logic [127:0] pair_sh;
   logic [63:0]  add22_r;
   assign pair_sh = {src_a, src_b} >> iss.pos;                 // RULE_06 RULE_07
   assign add22_r = src_b + {{42{iss.imm[21]}}, iss.imm[21:0]}; // RULE_08

   // result select
   logic [63:0] gr_res;
   logic        gr_op;
   assign gr_res =
      (iss.op == shift_field_compare_pkg::OP_SHL)    ? shl_r  :
      (iss.op == shift_field_compare_pkg::OP_SHR)    ? shr_r  :
      (iss.op == shift_field_compare_pkg::OP_SHRU)   ? shru_r :
      (iss.op == shift_field_compare_pkg::OP_EXTR ||
       iss.op == shift_field_compare_pkg::OP_EXTRU)  ? extr_r :
      (iss.op == shift_field_compare_pkg::OP_DEP ||
       iss.op == shift_field_compare_pkg::OP_DEPZ)   ? dep_r  :
      (iss.op == shift_field_compare_pkg::OP_SHRP)   ? pair_sh[63:0] :
      (iss.op == shift_field_compare_pkg::OP_ADDI22) ? add22_r :
      iss.imm;                                                 // RULE_09
   assign gr_op = (iss.op >= shift_field_compare_pkg::OP_SHL) &&
                  (iss.op <= shift_field_compare_pkg::OP_MOVL);

   // ***************************************************
   // integer compare
   // ***************************************************
   // narrow form rebuilds both operands from the low half only
   logic        narrow;
   logic [63:0] ua;
   logic [63:0] ub;
   logic [63:0] sa;
   logic [63:0] sb;
   logic        ieq;
   logic        ilt;
   logic        iltu;
   logic        icmp_r;
   assign narrow = (iss.op == shift_field_compare_pkg::OP_CMPN);
   assign ua = narrow ? {32'h0, src_a[31:0]} : src_a;          // RULE_15
   assign ub = narrow ? {32'h0, opnd_b[31:0]} : opnd_b;        // RULE_15
   assign sa = narrow ? {{32{src_a[31]}}, src_a[31:0]} : src_a;
   assign sb = narrow ? {{32{opnd_b[31]}}, opnd_b[31:0]} : opnd_b;
   assign ieq  = (ua == ub);
   assign ilt  = ($signed(sa) < $signed(sb));
   assign iltu = (ua < ub);
   assign icmp_r =
      (iss.rel == shift_field_compare_pkg::REL_EQ)  ? ieq :
      (iss.rel == shift_field_compare_pkg::REL_NE)  ? !ieq :
      (iss.rel == shift_field_compare_pkg::REL_LT)  ? ilt :
      (iss.rel == shift_field_compare_pkg::REL_LE)  ? (ilt | ieq) :
      (iss.rel == shift_field_compare_pkg::REL_GT)  ? !(ilt | ieq) :
      (iss.rel == shift_field_compare_pkg::REL_GE)  ? !ilt :
      (iss.rel == shift_field_compare_pkg::REL_LTU) ? iltu :
      (iss.rel == shift_field_compare_pkg::REL_LEU) ? (iltu | ieq) :
      (iss.rel == shift_field_compare_pkg::REL_GTU) ? !(iltu | ieq) :
      !iltu;                                                   // RULE_14

   // ***************************************************
   // floating-point compare, classify, approximations
   // ***************************************************
   logic nan_a, nan_b, inf_a, inf_b, zero_a, zero_b, den_a, unord;
   logic mag_lt, mag_gt, feq, flt, fcmp_r, fclass_r, approx_ok;
   assign nan_a  = (&iss.fa[62:52]) & (|iss.fa[51:0]);
   assign nan_b  = (&iss.fb[62:52]) & (|iss.fb[51:0]);
   assign inf_a  = (&iss.fa[62:52]) & ~(|iss.fa[51:0]);
   assign inf_b  = (&iss.fb[62:52]) & ~(|iss.fb[51:0]);
   assign zero_a = ~(|iss.fa[62:0]);
   assign zero_b = ~(|iss.fb[62:0]);
   assign den_a  = ~(|iss.fa[62:52]) & (|iss.fa[51:0]);
   assign unord  = nan_a | nan_b;
   assign mag_lt = iss.fa[62:0] < iss.fb[62:0];
   assign mag_gt = iss.fa[62:0] > iss.fb[62:0];
   // signed zeros compare equal
   assign feq = !unord && ((iss.fa == iss.fb) || (zero_a && zero_b));
   assign flt = !unord && !(zero_a && zero_b) &&
                ((iss.fa[63] && !iss.fb[63]) ||
                 (!iss.fa[63] && !iss.fb[63] && mag_lt) ||
                 (iss.fa[63] && iss.fb[63] && mag_gt));
   assign fcmp_r =
      (iss.rel[2:0] == shift_field_compare_pkg::FREL_EQ)    ? feq :
      (iss.rel[2:0] == shift_field_compare_pkg::FREL_LT)    ? flt :
      (iss.rel[2:0] == shift_field_compare_pkg::FREL_LE)    ? (flt | feq) :
      (iss.rel[2:0] == shift_field_compare_pkg::FREL_UNORD) ? unord :
      (iss.rel[2:0] == shift_field_compare_pkg::FREL_NEQ)   ? !feq :
      (iss.rel[2:0] == shift_field_compare_pkg::FREL_NLT)   ? !flt :
      (iss.rel[2:0] == shift_field_compare_pkg::FREL_NLE)   ? !(flt | feq) :
      !unord;                                                  // RULE_19
   // class mask in imm: sign bits 1:0, kind bits 5:2, nan bits 7:6
   assign fclass_r = (((iss.imm[0] & ~iss.fa[63]) | (iss.imm[1] & iss.fa[63])) &
                      ((iss.imm[2] & zero_a) | (iss.imm[3] & den_a) |
                       (iss.imm[4] & ~zero_a & ~den_a & ~inf_a & ~nan_a) |
                       (iss.imm[5] & inf_a))) |
                     (iss.imm[6] & nan_a & ~iss.fa[51]) |
                     (iss.imm[7] & nan_a & iss.fa[51]);        // RULE_20
   // special operands are left to the software fix-up path
   assign approx_ok = (iss.op == shift_field_compare_pkg::OP_FRCPA)
      ? !(nan_a | nan_b | inf_a | inf_b | zero_b)
      : !(nan_a | inf_a | zero_a | iss.fa[63]);                // RULE_21

   // ***************************************************
   // predicate target writes
   // ***************************************************
   logic cmp_op, approx_op, cmp_r, cmp_nat, go;
   assign cmp_op    = (iss.op >= shift_field_compare_pkg::OP_CMP) &&
                      (iss.op <= shift_field_compare_pkg::OP_FCLASS);
   assign approx_op = (iss.op == shift_field_compare_pkg::OP_FRCPA) ||
                      (iss.op == shift_field_compare_pkg::OP_FRSQRTA);
   assign cmp_r =
      (iss.op == shift_field_compare_pkg::OP_TBIT)  ? src_a[iss.pos] :      // RULE_16
      (iss.op == shift_field_compare_pkg::OP_TNAT)  ? nat_a :               // RULE_17
      (iss.op == shift_field_compare_pkg::OP_TFEAT) ? FEATURE_SET[iss.pos] : // RULE_18
      (iss.op == shift_field_compare_pkg::OP_FCMP)  ? fcmp_r :
      (iss.op == shift_field_compare_pkg::OP_FCLASS) ? fclass_r :
      icmp_r;
   // a marked source forces the targets off, or leaves or-type targets unchanged, rather than a bogus result
   assign cmp_nat = ((iss.op == shift_field_compare_pkg::OP_CMP ||
                      iss.op == shift_field_compare_pkg::OP_CMPN) && (nat_a | nat_b)) ||
                    ((iss.op == shift_field_compare_pkg::OP_TBIT) && nat_a);
   assign go = iss.valid & qp;                                 // RULE_10

   logic pw_we, pv1, pv2;
   assign pw_we = (iss.ctype == shift_field_compare_pkg::CT_NORMAL) ? go :  // RULE_22
                  (iss.ctype == shift_field_compare_pkg::CT_UNC)    ? iss.valid : // RULE_23
                  (iss.ctype == shift_field_compare_pkg::CT_AND)    ?
                     (go & (~cmp_r | cmp_nat)) :
                  (go & cmp_r & ~cmp_nat);
   assign pv1 = (iss.ctype == shift_field_compare_pkg::CT_AND) ? 1'b0 :
                (iss.ctype == shift_field_compare_pkg::CT_OR)  ? 1'b1 :
                (qp & cmp_r & ~cmp_nat);                       // RULE_22 RULE_23
   assign pv2 = (iss.ctype == shift_field_compare_pkg::CT_AND) ? 1'b0 :
                (iss.ctype == shift_field_compare_pkg::CT_OR)  ? 1'b1 :
                (qp & ~cmp_r & ~cmp_nat);                      // RULE_22 RULE_23

   // next write-back; approximations write a single target even if qp is false
   always_comb begin
      wb_d         = '0;
      wb_d.gr_idx  = iss.r1;
      wb_d.gr_data = gr_res;
      wb_d.gr_nat  = (iss.op == shift_field_compare_pkg::OP_MOVL) ? 1'b0 :
                     (iss.op == shift_field_compare_pkg::OP_ADDI22) ? nat_q[iss.r3] :
                     nat_a | (nat_b & (iss.op != shift_field_compare_pkg::OP_EXTR) &
                              (iss.op != shift_field_compare_pkg::OP_EXTRU));
      wb_d.gr_we   = go & gr_op & (iss.r1 != 7'h00);          // RULE_10 RULE_08
      wb_d.p1_idx  = iss.p1;
      wb_d.p2_idx  = iss.p2;
      wb_d.p1_we   = ((cmp_op & pw_we) | (iss.valid & approx_op)) &
                     (iss.p1 != 6'h00);                        // RULE_13 RULE_11
      wb_d.p2_we   = cmp_op & pw_we & (iss.p2 != 6'h00);       // RULE_13 RULE_11
      wb_d.p1_val  = approx_op ? (qp & approx_ok) : pv1;       // RULE_21
      wb_d.p2_val  = pv2;
      wb_d.ungated = iss.valid &&
                     (iss.op == shift_field_compare_pkg::OP_UNGATED); // RULE_12
   end

   // per-entry predicate update; entry zero stays constant true
   assign pred_d[0] = 1'b1;                                    // RULE_11
   genvar gi;
   generate
      for (gi = 1; gi < shift_field_compare_pkg::PR_COUNT; gi++) begin : g_pred
         assign pred_d[gi] =
            (wb_d.p2_we && wb_d.p2_idx == 6'(gi)) ? wb_d.p2_val :
            (wb_d.p1_we && wb_d.p1_idx == 6'(gi)) ? wb_d.p1_val :
            pred_q[gi];
      end
   endgenerate

   // marker bits: execution result wins over a load to the same entry
   always_comb begin
      nat_d = nat_q;
      if (load.we && load.idx != 7'h00) begin
         nat_d[load.idx] = load.deferred_exception_marker;
      end
      if (wb_d.gr_we) begin
         nat_d[wb_d.gr_idx] = wb_d.gr_nat;
      end
   end

   // ***************************************************
   // state
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_q   <= '0;
         pred_q <= shift_field_compare_pkg::PR_RESET;
         nat_q  <= shift_field_compare_pkg::NAT_RESET;
      end else begin
         wb_q   <= wb_d;
         pred_q <= pred_d;
         nat_q  <= nat_d;
      end
   end

   // data array has no reset; entry zero is masked on read
   always_ff @(posedge clk) begin
      if (wb_d.gr_we) begin
         gr_mem[wb_d.gr_idx] <= wb_d.gr_data;
      end
      if (load.we && load.idx != 7'h00 && !(wb_d.gr_we && wb_d.gr_idx == load.idx)) begin
         gr_mem[load.idx] <= load.data;
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [63:0] rot_exp;
   logic        is_normal, is_unc;
   assign rot_exp   = (src_a >> iss.pos) | (src_a << (7'd64 - {1'b0, iss.pos}));
   assign is_normal = cmp_op && iss.ctype == shift_field_compare_pkg::CT_NORMAL;
   assign is_unc    = cmp_op && iss.ctype == shift_field_compare_pkg::CT_UNC;

   sequence s_unc_false;
      iss.valid && is_unc && !qp && iss.p1 != 6'h00 && iss.p2 != 6'h00;
   endsequence
   sequence s_targets_zero;
      wb_q.p1_we && wb_q.p2_we && !wb_q.p1_val && !wb_q.p2_val && !pred_q[$past(iss.p1)];
   endsequence

   AST_GR0_NEVER_WRITTEN: assert property (wb_q.gr_we |-> wb_q.gr_idx != 7'h00) // RULE_08
      else $error("write to general register zero");
   AST_PR0_ONE: assert property (pred_q[0] && !(wb_q.p1_we && wb_q.p1_idx == 6'h00)) // RULE_11
      else $error("predicate zero not true");
   AST_FALSE_QP_QUIET: assert property (iss.valid && !qp |=> !wb_q.gr_we) // RULE_10
      else $error("gr written under false predicate");
   AST_UNGATED_RUNS: assert property (iss.valid && iss.op == shift_field_compare_pkg::OP_UNGATED
      && !qp |=> wb_q.ungated) // RULE_12
      else $error("ungated op suppressed");
   AST_UNC_ZEROES: assert property (s_unc_false |=> s_targets_zero) // RULE_23
      else $error("unconditional compare did not clear targets");
   AST_NORMAL_COMPLEMENT: assert property (go && is_normal && !cmp_nat && iss.p1 != 6'h00
      && iss.p2 != 6'h00 |=> wb_q.p1_we && wb_q.p2_we && wb_q.p1_val != wb_q.p2_val) // RULE_22
      else $error("normal compare targets not complementary");
   AST_APPROX_SINGLE: assert property (iss.valid && approx_op && iss.p1 != 6'h00
      |=> wb_q.p1_we && !wb_q.p2_we) // RULE_13
      else $error("approximation target count wrong");
   AST_SHL_SATURATE: assert property (go && iss.op == shift_field_compare_pkg::OP_SHL
      && cnt_big && iss.r1 != 7'h00 |=> wb_q.gr_we && wb_q.gr_data == 64'h0) // RULE_24
      else $error("large left shift not zero");
   AST_ROTATE: assert property (go && iss.op == shift_field_compare_pkg::OP_SHRP
      && iss.r2 == iss.r3 && iss.r1 != 7'h00 |=> wb_q.gr_data == $past(rot_exp)) // RULE_07
      else $error("pair shift of one register is not a rotate");
   AST_MOVL_FULL: assert property (go && iss.op == shift_field_compare_pkg::OP_MOVL
      && iss.r1 != 7'h00 |=> wb_q.gr_we && wb_q.gr_data == $past(iss.imm) && !wb_q.gr_nat) // RULE_09
      else $error("long move value wrong");

endmodule : shift_field_compare_unit

// ==== shift_field_compare_pkg.sv ====
// shared types and constants for the shift, field and compare datapath
package shift_field_compare_pkg;

   // ***************************************************
   // widths and reset values
   // ***************************************************
   localparam int              XLEN      = 64;
   localparam int              GR_COUNT  = 128;
   localparam int              PR_COUNT  = 64;
   localparam int              NARROW_W  = 32;
   localparam int              IMM22_W   = 22;
   localparam logic [63:0]     PR_RESET  = 64'h0000000000000001;
   localparam logic [127:0]    NAT_RESET = 128'h0;
   // feature set default; value is arbitrary
   localparam logic [63:0]     FEATURES_DEFAULT = 64'h0000000000000001;

   // ***************************************************
   // operation codes and selectors
   // ***************************************************
   typedef enum logic [4:0] {
      OP_NOP     = 5'b00000,
      OP_SHL     = 5'b00001,
      OP_SHR     = 5'b00010,
      OP_SHRU    = 5'b00011,
      OP_EXTR    = 5'b00100,
      OP_EXTRU   = 5'b00101,
      OP_DEP     = 5'b00110,
      OP_DEPZ    = 5'b00111,
      OP_SHRP    = 5'b01000,
      OP_ADDI22  = 5'b01001,
      OP_MOVL    = 5'b01010,
      OP_CMP     = 5'b01011,
      OP_CMPN    = 5'b01100,
      OP_TBIT    = 5'b01101,
      OP_TNAT    = 5'b01110,
      OP_TFEAT   = 5'b01111,
      OP_FCMP    = 5'b10000,
      OP_FCLASS  = 5'b10001,
      OP_FRCPA   = 5'b10010,
      OP_FRSQRTA = 5'b10011,
      OP_UNGATED = 5'b10100
   } op_e;

   typedef enum logic [1:0] {
      CT_NORMAL = 2'b00,
      CT_UNC    = 2'b01,
      CT_AND    = 2'b10,
      CT_OR     = 2'b11
   } ctype_e;

   typedef enum logic [1:0] {
      DS_REG   = 2'b00,
      DS_ZEROS = 2'b01,
      DS_ONES  = 2'b10
   } dsrc_e;

   // integer relations in rel, fp relations in rel[2:0]
   localparam logic [3:0] REL_EQ = 4'h0, REL_NE = 4'h1, REL_LT = 4'h2, REL_LE = 4'h3;
   localparam logic [3:0] REL_GT = 4'h4, REL_GE = 4'h5, REL_LTU = 4'h6;
   localparam logic [3:0] REL_LEU = 4'h7, REL_GTU = 4'h8, REL_GEU = 4'h9;
   localparam logic [2:0] FREL_EQ = 3'h0, FREL_LT = 3'h1, FREL_LE = 3'h2;
   localparam logic [2:0] FREL_UNORD = 3'h3, FREL_NEQ = 3'h4, FREL_NLT = 3'h5;
   localparam logic [2:0] FREL_NLE = 3'h6, FREL_ORD = 3'h7;

   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic        valid;
      op_e         op;
      logic [5:0]  qp;
      logic [6:0]  r1;
      logic [6:0]  r2;
      logic [6:0]  r3;
      logic [5:0]  p1;
      logic [5:0]  p2;
      ctype_e      ctype;
      logic [3:0]  rel;
      logic        use_imm;
      dsrc_e       dsrc;
      logic [5:0]  pos;
      logic [5:0]  len_m1;
      logic [63:0] imm;
      logic [63:0] fa;
      logic [63:0] fb;
   } issue_s;

   typedef struct packed {
      logic        we;
      logic [6:0]  idx;
      logic [63:0] data;
      logic        deferred_exception_marker;
   } grload_s;

   typedef struct packed {
      logic        gr_we;
      logic [6:0]  gr_idx;
      logic [63:0] gr_data;
      logic        gr_nat;
      logic        p1_we;
      logic [5:0]  p1_idx;
      logic        p1_val;
      logic        p2_we;
      logic [5:0]  p2_idx;
      logic        p2_val;
      logic        ungated;
   } wb_s;

endpackage : shift_field_compare_pkg

// ==== gr_writer.sv ====
// partner model: register-file write source feeding the load port
`timescale 1ns/100ps
module gr_writer (
   input  wire logic                              clk,   // core clock
   input  wire logic                              req,   // write request
   input  wire logic [6:0]                        idx,   // target register
   input  wire logic [64:0]                       dn,    // marker and data
   output      shift_field_compare_pkg::grload_s  load   // to the unit
);
   // idle data toggles so a stale value never passes for a fresh write
   initial load = '0;
   always @(posedge clk) begin
      load <= {req, idx, req ? dn[63:0] : ~load.data, dn[64]};
   end
endmodule : gr_writer

// ==== shift_field_compare_unit_test.sv ====
// self-checking bench for the shift, field and compare unit
`timescale 1ns/100ps
module shift_field_compare_unit_test;
   logic                              clk = 0, rst = 1, req = 0;
   logic [6:0]                        widx = '0;
   logic [64:0]                       wdn = '0;
   shift_field_compare_pkg::issue_s   iss = '0, x;
   shift_field_compare_pkg::grload_s  load;
   shift_field_compare_pkg::wb_s      wb_q;
   logic [63:0]                       pred_q;
   int                                errors = 0, check_count = 0;
   localparam logic [63:0] A = 64'h8000_0000_0000_00f0;
   localparam logic [63:0] ONE = 64'h3ff0_0000_0000_0000;
   always #50 clk = ~clk;
   gr_writer i_src (.clk(clk), .req(req), .idx(widx), .dn(wdn), .load(load));
   shift_field_compare_unit i_dut (.clk(clk), .rst(rst), .iss(iss), .load(load),
                                   .wb_q(wb_q), .pred_q(pred_q));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic chk(string n, logic [63:0] e, logic [63:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // default issue: destination 9, targets 3 and 4, qualifier always true
   function automatic shift_field_compare_pkg::issue_s mk(shift_field_compare_pkg::op_e o,
         logic [6:0] a, logic [6:0] b, logic [5:0] p, logic [5:0] l, logic [63:0] im);
      mk = {1'b1, o, 6'h0, 7'h09, a, b, 6'h03, 6'h04, 2'h0, 4'h0, 1'b0, 2'h0, p, l, im, 128'h0};
   endfunction : mk
   // load port write, visible from the third edge on
   task automatic wr(logic [6:0] i, logic [64:0] v);
      @(posedge clk) begin req <= 1; widx <= i; wdn <= v; end
      @(posedge clk) req <= 0;
      @(posedge clk);
   endtask : wr
   // one issue; write-back stands only in the following cycle
   task automatic run(shift_field_compare_pkg::issue_s s);
      @(posedge clk) iss <= s;
      @(posedge clk) iss.valid <= 1'b0;
      #1;
   endtask : run
   task automatic gr_op(string n, shift_field_compare_pkg::issue_s s, logic [63:0] e);
      run(s);
      chk(n, e, wb_q.gr_data);
      chk("gr_we", 64'h1, {63'h0, wb_q.gr_we});
      chk("gr_idx", 64'h9, {57'h0, wb_q.gr_idx});
   endtask : gr_op
   // predicate writes as {p1_we, p1_val, p2_we, p2_val}
   task automatic pc(string n, shift_field_compare_pkg::issue_s s, logic [3:0] e);
      run(s);
      chk(n, {60'h0, e}, {60'h0, wb_q.p1_we, wb_q.p1_val, wb_q.p2_we, wb_q.p2_val & wb_q.p2_we});
      chk("p_idx", 64'hc4, {52'h0, wb_q.p1_idx, wb_q.p2_idx});
   endtask : pc
   task automatic t_shift();
      gr_op("shl", mk(shift_field_compare_pkg::OP_SHL, 1, 2, 0, 0, 0), 64'hf00);
      gr_op("shr", mk(shift_field_compare_pkg::OP_SHR, 1, 2, 0, 0, 0), 64'hf800_0000_0000_000f);
      gr_op("shru", mk(shift_field_compare_pkg::OP_SHRU, 1, 2, 0, 0, 0), 64'h0800_0000_0000_000f);
      gr_op("shl70", mk(shift_field_compare_pkg::OP_SHL, 1, 3, 0, 0, 0), 64'h0);
      gr_op("shr70", mk(shift_field_compare_pkg::OP_SHR, 1, 3, 0, 0, 0), '1);
      gr_op("shru70", mk(shift_field_compare_pkg::OP_SHRU, 1, 3, 0, 0, 0), 64'h0);
   endtask : t_shift
   task automatic t_field();
      gr_op("extr", mk(shift_field_compare_pkg::OP_EXTR, 1, 0, 60, 3, 0), 64'hffff_ffff_ffff_fff8);
      gr_op("extru", mk(shift_field_compare_pkg::OP_EXTRU, 1, 0, 60, 3, 0), 64'h8);
      gr_op("depz", mk(shift_field_compare_pkg::OP_DEPZ, 1, 0, 8, 55, 0), 64'hf000);
      gr_op("dep", mk(shift_field_compare_pkg::OP_DEP, 2, 1, 8, 7, 0), 64'h8000_0000_0000_04f0);
      x = mk(shift_field_compare_pkg::OP_DEP, 2, 3, 4, 3, 0);
      x.dsrc = shift_field_compare_pkg::DS_ONES;
      gr_op("dep_ones", x, 64'hf6);
   endtask : t_field
   task automatic t_pair_const();
      gr_op("rot", mk(shift_field_compare_pkg::OP_SHRP, 1, 1, 8, 0, 0), 64'hf080_0000_0000_0000);
      gr_op("pair", mk(shift_field_compare_pkg::OP_SHRP, 2, 1, 4, 0, 0), 64'h4800_0000_0000_000f);
      gr_op("add22", mk(shift_field_compare_pkg::OP_ADDI22, 1, 0, 0, 0, 64'h12345), 64'h12345);
      gr_op("movl", mk(shift_field_compare_pkg::OP_MOVL, 0, 0, 0, 0, 64'hdead_beef_0123_4567), 64'hdead_beef_0123_4567);
   endtask : t_pair_const
   // all ten relations, negative first operand against 4
   task automatic t_cmp();
      logic [9:0] e;
      e = 10'h30e;
      for (int k = 0; k < 10; k++) begin
         x = mk(shift_field_compare_pkg::OP_CMP, 1, 2, 0, 0, 0);
         x.rel = k[3:0];
         pc("rel", x, {1'b1, e[k], 1'b1, ~e[k]});
      end
      pc("wide", mk(shift_field_compare_pkg::OP_CMP, 4, 2, 0, 0, 0), 4'b1011);
      pc("narrow", mk(shift_field_compare_pkg::OP_CMPN, 4, 2, 0, 0, 0), 4'b1110);
      chk("pred34", 64'h1, {62'h0, pred_q[4:3]});
      x = mk(shift_field_compare_pkg::OP_CMP, 2, 0, 0, 0, 5);
      x.use_imm = 1'b1;
      x.ctype = shift_field_compare_pkg::CT_AND;
      pc("and_imm", x, 4'b1010);
      x.imm = 4;
      x.ctype = shift_field_compare_pkg::CT_OR;
      pc("or_imm", x, 4'b1111);
      chk("pred0", 64'h1, {63'h0, pred_q[0]});
   endtask : t_cmp
   // qualifier 5 is false after reset
   task automatic t_pred();
      x = mk(shift_field_compare_pkg::OP_SHL, 1, 2, 0, 0, 0);
      x.qp = 5;
      run(x);
      chk("qp_gr_we", 64'h0, {63'h0, wb_q.gr_we});
      x.op = shift_field_compare_pkg::OP_CMP;
      pc("qp_normal", x, 4'b0000);
      x.ctype = shift_field_compare_pkg::CT_UNC;
      pc("qp_unc", x, 4'b1010);
      x.op = shift_field_compare_pkg::OP_UNGATED;
      run(x);
      chk("ungated", 64'h1, {63'h0, wb_q.ungated});
   endtask : t_pred
   task automatic t_test();
      pc("tbit", mk(shift_field_compare_pkg::OP_TBIT, 1, 0, 63, 0, 0), 4'b1110);
      pc("tnat", mk(shift_field_compare_pkg::OP_TNAT, 6, 0, 0, 0, 0), 4'b1110);
      pc("tf", mk(shift_field_compare_pkg::OP_TFEAT, 0, 0, 0, 0, 0), 4'b1110);
      x = mk(shift_field_compare_pkg::OP_FCMP, 0, 0, 0, 0, 0);
      x.fa = ONE;
      x.fb = ONE;
      pc("fcmp", x, 4'b1110);
      x.op = shift_field_compare_pkg::OP_FCLASS;
      x.imm = 64'h11;
      pc("fclass", x, 4'b1110);
      x.op = shift_field_compare_pkg::OP_FRCPA;
      pc("frcpa_ok", x, 4'b1100);
      x.fa = 0;
      x.fb = 0;
      pc("frcpa_bad", x, 4'b1000);
   endtask : t_test
   // watchdog: a run needs well under 2000 cycles
   initial begin
      #1000000;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      wr(1, {1'b0, A});
      wr(2, 65'h4);
      wr(3, 65'h46);
      wr(4, 65'h0_ffff_ffff_0000_0004);
      wr(6, {1'b1, 64'h0});
      t_shift();
      t_field();
      t_pair_const();
      t_cmp();
      t_pred();
      t_test();
      tally_and_finish();
   end
endmodule : shift_field_compare_unit_test
